// ### logic/sscr_pkg.sv
// constants for the serial configuration register bank
`default_nettype none
package sscr_pkg;
    localparam int WORD_W = 32;
    localparam int NUM_REGS = 6;
    localparam int SEL_W = 3;
    localparam int SEL_LSB = 0;
    localparam logic [2:0] SEL_R0 = 3'h0;
    localparam logic [2:0] SEL_R1 = 3'h1;
    localparam logic [2:0] SEL_R2 = 3'h2;
    localparam logic [2:0] SEL_R3 = 3'h3;
    localparam logic [2:0] SEL_R4 = 3'h4;
    localparam logic [2:0] SEL_R5 = 3'h5;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;
    // divider_integer_fraction
    localparam int INT_LSB = 15;
    localparam int INT_W = 16;
    localparam int NUMER_LSB = 3;
    localparam int NUMER_W = 12;
    // prescaler_phase_modulus
    localparam int PRESC_BIT = 27;
    localparam int PHASE_LSB = 15;
    localparam int PHASE_W = 12;
    localparam int MODULUS_LSB = 3;
    localparam int MODULUS_W = 12;
    // reference_pump_lock_config
    localparam int NOISE_LSB = 29;
    localparam int NOISE_W = 2;
    localparam int TPS_LSB = 26;
    localparam int TPS_W = 3;
    localparam int DOUBLER_BIT = 25;
    localparam int RDIV2_BIT = 24;
    localparam int RCNT_LSB = 14;
    localparam int RCNT_W = 10;
    localparam int DBL_EN_BIT = 13;
    localparam int CP_LSB = 9;
    localparam int CP_W = 3;
    localparam int LDF_BIT = 8;
    localparam int LDP_BIT = 7;
    localparam int PD_BIT = 5;
    localparam int TRI_BIT = 4;
    localparam int CRST_BIT = 3;
    // clock_divider_boost_config
    localparam int BOOST_BIT = 18;
    localparam int CDMODE_LSB = 15;
    localparam int CDMODE_W = 2;
    localparam int CDIV_LSB = 3;
    localparam int CDIV_W = 12;
    // output_stage_config
    localparam int FBSEL_BIT = 23;
    localparam int DIVSEL_LSB = 20;
    localparam int DIVSEL_W = 3;
    localparam int MTLD_BIT = 10;
    localparam int RFEN_BIT = 5;
    localparam int OPWR_LSB = 3;
    localparam int OPWR_W = 2;
    // lock_pin_bleed_config
    localparam int LDPIN_LSB = 22;
    localparam int LDPIN_W = 2;
endpackage : sscr_pkg
`default_nettype wire

// ### logic/sscr_word_if.sv
// carries the shifted word from the serial-clock domain to the register bank
`timescale 1ns/1ps
`default_nettype none
interface sscr_word_if #(parameter int WIDTH = 32);
    logic [WIDTH-1:0] word;
    modport src (output word);
    modport dst (input word);
endinterface : sscr_word_if
`default_nettype wire

// ### logic/sscr_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sscr_sync
    import sscr_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // destination clock
    input wire logic nrst_in, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // foreign level
    output logic [WIDTH-1:0] sync_out // synchronised level
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    if (WIDTH < 1) begin : g_width_check
        $error("sscr_sync: WIDTH must be at least 1");
    end

    // meta_ff is read by stable_ff only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule : sscr_sync
`default_nettype wire

// ### logic/sscr_shifter.sv
// serial-clock shift register, msb first
`timescale 1ns/1ps
`default_nettype none
module sscr_shifter
    import sscr_pkg::*;
(
    input wire logic sclk_in, // serial link clock
    input wire logic nrst_in, // async reset, active low
    input wire logic sdata_in, // serial data
    sscr_word_if.src word_if // shifted word
);
    logic [WORD_W-1:0] shift_ff;

    // the newest bit enters at bit 0, so the first bit ends at bit 31
    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_ff <= WORD_RST;
        end else begin
            shift_ff <= {shift_ff[WORD_W-2:0], sdata_in}; // [R10]
        end
    end

    assign word_if.word = shift_ff;
endmodule : sscr_shifter
`default_nettype wire

// ### logic/sscr_config_regs.sv
// configuration register bank loaded over the 3-wire serial link
// How it works
// [R1] select 000 stores word in divider register
// [R2] integer divide value in bits 30..15
// [R3] host: 4/5 prescaler integer 23..32767
// [R4] host: 8/9 prescaler integer 75..65535
// [R5] fraction numerator in bits 14..3
// [R6] host: numerator below the fractional modulus
// [R7] buffered fields apply at next divider write
// [R8] divider select buffered only if flag set
// [R9] host: selector must pick digital lock detect
// [R10] shift 32 bits msb first on rising clock
// [R11] strobe rising edge copies word into latch
// [R12] select 001 stores prescaler/phase/modulus register
// [R13] host: reserved bits written with fixed values
// [R14] host: finish changes with a divider write
`timescale 1ns/1ps
`default_nettype none
module sscr_config_regs
    import sscr_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int REGS = NUM_REGS
) (
    input wire logic clk_in, // system clock, 100 MHz
    input wire logic nrst_in, // async reset, active low
    input wire logic sclk_in, // serial link clock
    input wire logic sdata_in, // serial data, msb first
    input wire logic load_strobe_in, // word load strobe
    output logic [INT_W-1:0] int_value_out, // integer divide value
    output logic [NUMER_W-1:0] fraction_numerator_out, // fraction numerator
    output logic prescaler_out, // 1 selects 8/9
    output logic [PHASE_W-1:0] phase_out, // phase word, buffered
    output logic [MODULUS_W-1:0] fractional_modulus_out, // modulus, buffered
    output logic [NOISE_W-1:0] noise_mode_out, // noise/spur mode
    output logic [TPS_W-1:0] test_point_selector_out, // test point select
    output logic doubler_out, // reference doubler, buffered
    output logic rdiv2_out, // reference halver, buffered
    output logic [RCNT_W-1:0] ref_count_out, // reference divider, buffered
    output logic buffer_divsel_out, // divider select buffering enable
    output logic [CP_W-1:0] pump_current_out, // pump current, buffered
    output logic lock_cycles_out, // lock detect cycle count select
    output logic lock_precision_out, // lock detect window select
    output logic power_down_out, // power down
    output logic pump_tristate_out, // pump three-state
    output logic counter_reset_out, // counter reset
    output logic boost_out, // boost enable
    output logic [CDMODE_W-1:0] clk_div_mode_out, // clock divider mode
    output logic [CDIV_W-1:0] clk_div_value_out, // clock divider value
    output logic feedback_select_out, // feedback select
    output logic [DIVSEL_W-1:0] divider_select_out, // output divider select
    output logic mute_till_lock_out, // mute until lock
    output logic rf_enable_out, // output stage enable
    output logic [OPWR_W-1:0] out_power_out, // output power level
    output logic [LDPIN_W-1:0] lock_pin_mode_out, // lock pin mode
    output logic divider_load_out, // one-cycle pulse on divider write
    output logic pending_out, // buffered settings wait for divider write
    output logic bad_select_out // last word had an unused select code
);
    localparam int RIDX_W = $clog2(REGS);

    logic strobe_sync;
    logic strobe_q_ff;
    logic load_pulse;
    logic [SEL_W-1:0] sel;
    logic sel_ok;
    logic wr0;
    logic wr1;
    logic wr2;
    logic wr4;
    logic [WIDTH-1:0] hold_ff [REGS];
    logic [PHASE_W-1:0] phase_ff;
    logic [MODULUS_W-1:0] modulus_ff;
    logic doubler_ff;
    logic rdiv2_ff;
    logic [RCNT_W-1:0] rcnt_ff;
    logic [CP_W-1:0] cp_ff;
    logic [DIVSEL_W-1:0] divsel_ff;
    logic r0_pulse_ff;
    logic pending_ff;
    logic bad_sel_ff;

    sscr_word_if #(.WIDTH(WIDTH)) word_if ();

    // field positions are fixed to a 32-bit word with six latches
    if (WIDTH != 32) begin : g_width_check
        $error("sscr_config_regs: WIDTH must be 32");
    end
    if (REGS != 6) begin : g_regs_check
        $error("sscr_config_regs: REGS must be 6");
    end

    sscr_shifter u_shifter (
        .sclk_in(sclk_in),
        .nrst_in(nrst_in),
        .sdata_in(sdata_in),
        .word_if(word_if.src)
    );

    sscr_sync #(.WIDTH(1)) u_strobe_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in(load_strobe_in),
        .sync_out(strobe_sync)
    );

    // rising edge of the synchronised strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strobe_q_ff <= 1'b0;
        end else begin
            strobe_q_ff <= strobe_sync;
        end
    end

    assign load_pulse = strobe_sync & ~strobe_q_ff; // [R11]

    // the shifted word is read across domains without its own synchroniser:
    // the host holds the serial clock still while the strobe rises, so the
    // word has been static for at least two system cycles by load_pulse
    assign sel = word_if.word[SEL_LSB +: SEL_W];
    assign sel_ok = load_pulse && (sel <= SEL_R5); // [R11]
    assign wr0 = sel_ok && (sel == SEL_R0); // [R1]
    assign wr1 = sel_ok && (sel == SEL_R1); // [R12]
    assign wr2 = sel_ok && (sel == SEL_R2);
    assign wr4 = sel_ok && (sel == SEL_R4);

    // one holding latch per register; select codes 110 and 111 are dropped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < REGS; i++) begin
                hold_ff[i] <= WORD_RST;
            end
        end else if (sel_ok) begin
            hold_ff[sel[RIDX_W-1:0]] <= word_if.word; // [R11]
        end
    end

    // double-buffered reference and modulus settings move on a divider write
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_ff <= '0;
            modulus_ff <= '0;
        end else if (wr0) begin
            phase_ff <= hold_ff[SEL_R1][PHASE_LSB +: PHASE_W]; // [R7]
            modulus_ff <= hold_ff[SEL_R1][MODULUS_LSB +: MODULUS_W]; // [R7]
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            doubler_ff <= 1'b0;
            rdiv2_ff <= 1'b0;
            rcnt_ff <= '0;
            cp_ff <= '0;
        end else if (wr0) begin
            doubler_ff <= hold_ff[SEL_R2][DOUBLER_BIT]; // [R7]
            rdiv2_ff <= hold_ff[SEL_R2][RDIV2_BIT]; // [R7]
            rcnt_ff <= hold_ff[SEL_R2][RCNT_LSB +: RCNT_W]; // [R7]
            cp_ff <= hold_ff[SEL_R2][CP_LSB +: CP_W]; // [R7]
        end
    end

    // the enable flag is the one already latched, not one arriving later
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            divsel_ff <= '0;
        end else if (wr4 && !hold_ff[SEL_R2][DBL_EN_BIT]) begin
            divsel_ff <= word_if.word[DIVSEL_LSB +: DIVSEL_W]; // [R8]
        end else if (wr0) begin
            divsel_ff <= hold_ff[SEL_R4][DIVSEL_LSB +: DIVSEL_W]; // [R8]
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r0_pulse_ff <= 1'b0;
        end else begin
            r0_pulse_ff <= wr0;
        end
    end

    // a divider write commits everything, so it clears the pending state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pending_ff <= 1'b0;
        end else if (wr0) begin
            pending_ff <= 1'b0; // [R7]
        end else if (wr1 || wr2 || (wr4 && hold_ff[SEL_R2][DBL_EN_BIT])) begin
            pending_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bad_sel_ff <= 1'b0;
        end else if (load_pulse) begin
            bad_sel_ff <= !sel_ok;
        end
    end

    // immediate fields come straight from the holding latches
    assign int_value_out = hold_ff[SEL_R0][INT_LSB +: INT_W]; // [R2]
    assign fraction_numerator_out = hold_ff[SEL_R0][NUMER_LSB +: NUMER_W]; // [R5]
    assign prescaler_out = hold_ff[SEL_R1][PRESC_BIT];
    assign phase_out = phase_ff;
    assign fractional_modulus_out = modulus_ff;
    assign noise_mode_out = hold_ff[SEL_R2][NOISE_LSB +: NOISE_W];
    assign test_point_selector_out = hold_ff[SEL_R2][TPS_LSB +: TPS_W];
    assign doubler_out = doubler_ff;
    assign rdiv2_out = rdiv2_ff;
    assign ref_count_out = rcnt_ff;
    assign buffer_divsel_out = hold_ff[SEL_R2][DBL_EN_BIT];
    assign pump_current_out = cp_ff;
    assign lock_cycles_out = hold_ff[SEL_R2][LDF_BIT];
    assign lock_precision_out = hold_ff[SEL_R2][LDP_BIT];
    assign power_down_out = hold_ff[SEL_R2][PD_BIT];
    assign pump_tristate_out = hold_ff[SEL_R2][TRI_BIT];
    assign counter_reset_out = hold_ff[SEL_R2][CRST_BIT];
    assign boost_out = hold_ff[SEL_R3][BOOST_BIT];
    assign clk_div_mode_out = hold_ff[SEL_R3][CDMODE_LSB +: CDMODE_W];
    assign clk_div_value_out = hold_ff[SEL_R3][CDIV_LSB +: CDIV_W];
    assign feedback_select_out = hold_ff[SEL_R4][FBSEL_BIT];
    assign divider_select_out = divsel_ff;
    assign mute_till_lock_out = hold_ff[SEL_R4][MTLD_BIT];
    assign rf_enable_out = hold_ff[SEL_R4][RFEN_BIT];
    assign out_power_out = hold_ff[SEL_R4][OPWR_LSB +: OPWR_W];
    assign lock_pin_mode_out = hold_ff[SEL_R5][LDPIN_LSB +: LDPIN_W];
    assign divider_load_out = r0_pulse_ff;
    assign pending_out = pending_ff;
    assign bad_select_out = bad_sel_ff;
endmodule : sscr_config_regs
`default_nettype wire

// ### verification/sscr_assertions.sv
// concurrent checks on the ports of the serial config register bank
`timescale 1ns/1ps
`default_nettype none
module sscr_assertions
    import sscr_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic load_strobe_in, // load strobe
    input wire logic [INT_W-1:0] int_value_out, // integer value
    input wire logic [NUMER_W-1:0] fraction_numerator_out, // numerator
    input wire logic [PHASE_W-1:0] phase_out, // phase word
    input wire logic [MODULUS_W-1:0] fractional_modulus_out, // modulus
    input wire logic [RCNT_W-1:0] ref_count_out, // reference divider
    input wire logic [CP_W-1:0] pump_current_out, // pump current
    input wire logic [DIVSEL_W-1:0] divider_select_out, // divider select
    input wire logic buffer_divsel_out, // divider select buffering
    input wire logic divider_load_out, // divider write pulse
    input wire logic pending_out, // buffered settings waiting
    input wire logic bad_select_out // unused select seen
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence s_load;
        divider_load_out;
    endsequence
    sequence s_strobe_recent;
        $past(load_strobe_in, 2) || $past(load_strobe_in, 3) || $past(load_strobe_in, 4);
    endsequence
    property p_pulse;
        s_load |=> !divider_load_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("divider load pulse too long");
    property p_int;
        !$stable(int_value_out) |-> s_load;
    endproperty
    a_int: assert property (p_int) else $error("integer value moved without divider write");
    property p_numer;
        !$stable(fraction_numerator_out) |-> s_load;
    endproperty
    a_numer: assert property (p_numer) else $error("numerator moved without divider write");
    property p_dbuf;
        !$stable({phase_out, fractional_modulus_out, ref_count_out, pump_current_out}) |-> s_load;
    endproperty
    a_dbuf: assert property (p_dbuf) else $error("buffered field applied early");
    property p_divsel;
        !$stable(divider_select_out) && !divider_load_out |-> !buffer_divsel_out;
    endproperty
    a_divsel: assert property (p_divsel) else $error("divider select bypassed its buffer");
    property p_pend;
        s_load |=> !pending_out;
    endproperty
    a_pend: assert property (p_pend) else $error("pending not cleared by divider write");
    property p_cause;
        s_load |-> s_strobe_recent;
    endproperty
    a_cause: assert property (p_cause) else $error("divider write without load strobe");
    property p_bad;
        $rose(bad_select_out) |-> !divider_load_out && $stable(int_value_out);
    endproperty
    a_bad: assert property (p_bad) else $error("unused select stored a word");
endmodule : sscr_assertions
bind sscr_config_regs sscr_assertions i_chk (.clk_in, .nrst_in, .load_strobe_in, .int_value_out,
    .fraction_numerator_out, .phase_out, .fractional_modulus_out, .ref_count_out, .pump_current_out,
    .divider_select_out, .buffer_divsel_out, .divider_load_out, .pending_out, .bad_select_out);
`default_nettype wire

// ### verification/sscr_host_model.sv
// host side of the 3-wire link: shifts words and pulses the load strobe
`timescale 1ns/1ps
`default_nettype none
module sscr_host_model (
    input wire logic clk_in, // system clock, paces the strobe
    output logic sclk_out, // serial clock, still outside frames
    output logic sdata_out, // serial data
    output logic strobe_out // load strobe
);
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        strobe_out = 1'b0;
    end
    // callers build words with reserved bits at their fixed values
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sdata_out = w[i];
            #3 sclk_out = 1'b1;
            #3 sclk_out = 1'b0;
        end
        sdata_out = ~w[0]; // no stale bit left on the line
        @(posedge clk_in);
        #1 strobe_out = 1'b1;
        repeat (5) @(posedge clk_in);
        #1 strobe_out = 1'b0;
        // low time plus the synchroniser delay before anyone looks
        repeat (8) @(posedge clk_in);
    endtask : send_word
endmodule : sscr_host_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the serial config register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sscr_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    wire logic sclk, sdata, strobe;
    logic [15:0] int_value_out;
    logic [11:0] fraction_numerator_out, phase_out, fractional_modulus_out, clk_div_value_out;
    logic [9:0] ref_count_out;
    logic [2:0] test_point_selector_out, pump_current_out, divider_select_out;
    logic [1:0] lock_pin_mode_out, noise_mode_out, clk_div_mode_out, out_power_out;
    logic prescaler_out, doubler_out, rdiv2_out, buffer_divsel_out, boost_out, pending_out, bad_select_out;
    logic lock_cycles_out, lock_precision_out, power_down_out, pump_tristate_out, counter_reset_out;
    logic feedback_select_out, mute_till_lock_out, rf_enable_out, divider_load_out;
    int err_total = 0;
    int n_compared = 0;
    int n_loads = 0;
    always #5 clk_in = ~clk_in;
    // the load pulse stands one cycle, so it is counted away from the edge that launches it
    always @(negedge clk_in) begin
        if (divider_load_out === 1'b1) n_loads++;
    end
    sscr_host_model i_host (.clk_in, .sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));
    sscr_config_regs i_dut (.clk_in, .nrst_in, .sclk_in(sclk), .sdata_in(sdata), .load_strobe_in(strobe),
        .int_value_out, .fraction_numerator_out, .prescaler_out, .phase_out, .fractional_modulus_out,
        .noise_mode_out, .test_point_selector_out, .doubler_out, .rdiv2_out, .ref_count_out,
        .buffer_divsel_out, .pump_current_out, .lock_cycles_out, .lock_precision_out, .power_down_out,
        .pump_tristate_out, .counter_reset_out, .boost_out, .clk_div_mode_out, .clk_div_value_out,
        .feedback_select_out, .divider_select_out, .mute_till_lock_out, .rf_enable_out,
        .out_power_out, .lock_pin_mode_out, .divider_load_out, .pending_out, .bad_select_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic t_divider;
        i_host.send_word({4'h0, 1'b1, 12'h123, 12'hfff, 3'h1});
        chk(32'(prescaler_out), 32'h1);
        chk(32'({phase_out, fractional_modulus_out}), 32'h0);
        chk(32'(pending_out), 32'h1);
        i_host.send_word({1'b0, 16'hffff, 12'hffe, 3'h0});
        chk(32'(int_value_out), 32'hffff);
        chk(32'(fraction_numerator_out), 32'hffe);
        chk(32'({phase_out, fractional_modulus_out}), 32'h123fff);
        chk(32'(pending_out), 32'h0);
        chk(32'(n_loads), 32'h1);
        $display("t_divider done");
    endtask : t_divider
    task automatic t_buffers;
        i_host.send_word({1'b0, 2'h1, 3'h6, 2'h2, 10'h3ff, 2'h2, 3'h5, 3'h1, 3'h0, 3'h2});
        chk(32'({test_point_selector_out, buffer_divsel_out}), 32'hd);
        chk(32'({doubler_out, rdiv2_out, ref_count_out, pump_current_out}), 32'h0);
        i_host.send_word({8'h0, 1'b0, 3'h5, 9'h0, 1'b0, 4'h0, 1'b1, 2'h3, 3'h4});
        chk(32'(divider_select_out), 32'h0);
        chk(32'({feedback_select_out, mute_till_lock_out, rf_enable_out, out_power_out}), 32'h7);
        i_host.send_word({1'b0, 16'h004b, 12'h000, 3'h0});
        chk(32'({doubler_out, rdiv2_out, ref_count_out, pump_current_out}), 32'h5ffd);
        chk(32'(divider_select_out), 32'h5);
        chk(32'(int_value_out), 32'h4b);
        i_host.send_word({1'b0, 2'h2, 3'h6, 2'h2, 10'h3ff, 2'h0, 3'h5, 3'h7, 3'h7, 3'h2});
        chk(32'(noise_mode_out), 32'h2);
        chk(32'({lock_cycles_out, lock_precision_out}), 32'h3);
        chk(32'({power_down_out, pump_tristate_out, counter_reset_out}), 32'h7);
        i_host.send_word({8'h0, 1'b1, 3'h2, 9'h0, 1'b1, 4'h0, 1'b0, 2'h1, 3'h4});
        chk(32'(divider_select_out), 32'h2);
        chk(32'({feedback_select_out, mute_till_lock_out, rf_enable_out, out_power_out}), 32'h19);
        $display("t_buffers done");
    endtask : t_buffers
    task automatic t_misc;
        i_host.send_word({13'h0, 1'b1, 1'b0, 2'h2, 12'habc, 3'h3});
        chk(32'({boost_out, clk_div_mode_out, clk_div_value_out}), 32'h6abc);
        i_host.send_word({3'h0, 1'b1, 4'h0, 2'h3, 19'h0, 3'h5});
        chk(32'(lock_pin_mode_out), 32'h3);
        i_host.send_word({1'b0, 16'h1234, 12'h000, 3'h7});
        chk(32'(bad_select_out), 32'h1);
        chk(32'(int_value_out), 32'h4b);
        i_host.send_word({4'h0, 1'b0, 12'h001, 12'h0c8, 3'h1});
        chk(32'({bad_select_out, prescaler_out, pending_out}), 32'h1);
        i_host.send_word({1'b0, 16'h1234, 12'h000, 3'h6});
        chk(32'({bad_select_out, int_value_out}), 32'h1004b);
        i_host.send_word({1'b0, 16'h0017, 12'h0c7, 3'h0});
        chk(32'({int_value_out, fraction_numerator_out}), 32'h170c7);
        chk(32'({phase_out, fractional_modulus_out}), 32'h0010c8);
        chk(32'({bad_select_out, pending_out}), 32'h0);
        chk(32'(n_loads), 32'h3);
        $display("t_misc done");
    endtask : t_misc
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        t_divider();
        t_buffers();
        t_misc();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
